// ### bench/ccpu_checker.sv
// port checker of the capture/compare/pwm unit
`timescale 1ns/10ps
module ccpu_checker
    import ccpu_pkg::*;
(
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic [3:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0]  AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        CAPTURE_PIN_I,
    input wire logic        PWM_OUTPUT_PIN_O,
    input wire logic        PWM_OUTPUT_PIN_OE_O,
    input wire logic        IRQ_O
);
    logic [3:0]  mode_sh;   // shadow of the mode field
    logic [1:0]  duty_lo;   // shadow of duty low bits
    logic [7:0]  per_sh;    // shadow of period
    logic [7:0]  duty_sh;   // shadow of duty high byte
    logic [1:0]  pre_sh;    // shadow of pwm prescale select
    logic [3:0]  mask_sh;   // shadow of mask
    logic        valid;     // a rising edge seen since last taken write or pin disable
    logic        pin_q;     // pin one cycle back
    logic [31:0] since;     // cycles since last rise
    logic        take;      // write taken this edge
    logic [31:0] scale;     // pwm prescale ratio
    assign take  = AVS_WRITE_I && AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
    assign scale = (pre_sh == 2'h0) ? 32'h1 : (pre_sh == 2'h1) ? 32'h4 : 32'h10;
    // shadows follow taken writes; any taken write voids the running measurement
    always_ff @(posedge REF_CLK_I) begin
        pin_q <= PWM_OUTPUT_PIN_O;
        since <= (PWM_OUTPUT_PIN_O && !pin_q) ? 32'h1 : since + 32'h1;
        if (RST_I) begin
            {duty_lo, mode_sh} <= 6'h0;
            per_sh <= PERIOD_RESET;
            duty_sh <= 8'h0;
            pre_sh <= 2'h0;
            mask_sh <= 4'h0;
            valid <= 1'b0;
        end else begin
            if (take && AVS_ADDRESS_I == OFS_CONTROL) {duty_lo, mode_sh} <= AVS_WRITEDATA_I[5:0];
            if (take && AVS_ADDRESS_I == OFS_PERIOD) per_sh <= AVS_WRITEDATA_I[7:0];
            if (take && AVS_ADDRESS_I == OFS_DUTY_HI) duty_sh <= AVS_WRITEDATA_I[7:0];
            if (take && AVS_ADDRESS_I == OFS_PRESCALE) pre_sh <= AVS_WRITEDATA_I[5:4];
            if (take && AVS_ADDRESS_I == OFS_MASK) mask_sh <= AVS_WRITEDATA_I[3:0];
            valid <= (take || !PWM_OUTPUT_PIN_OE_O) ? 1'b0 : (PWM_OUTPUT_PIN_O && !pin_q) ? 1'b1 : valid;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_taken; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O; endsequence
    sequence s_irq_soon; ##[1:8] IRQ_O; endsequence
    property p_wait_one; s_taken |=> !AVS_WAITREQUEST_O; endproperty
    property p_wait_idle; !AVS_READ_I && !AVS_WRITE_I |-> !AVS_WAITREQUEST_O; endproperty
    property p_oe; $stable(mode_sh) |-> PWM_OUTPUT_PIN_OE_O == (mode_sh >= MODE_PWM); endproperty
    property p_gated; !PWM_OUTPUT_PIN_OE_O |-> !PWM_OUTPUT_PIN_O; endproperty
    property p_period;
        $rose(PWM_OUTPUT_PIN_O) && valid |-> since == ({24'h0, per_sh} + 32'h1) * PWM_CLKS_PER_TICK * scale;
    endproperty
    property p_duty;
        $fell(PWM_OUTPUT_PIN_O) && PWM_OUTPUT_PIN_OE_O && valid && {duty_sh, duty_lo} != 10'h0
            |-> since == {22'h0, duty_sh, duty_lo} * scale;
    endproperty
    property p_capture;
        mask_sh[EV_CAPTURE] && ($rose(CAPTURE_PIN_I) && mode_sh == MODE_CAP_RISE
            || $fell(CAPTURE_PIN_I) && mode_sh == MODE_CAP_FALL) |-> s_irq_soon;
    endproperty
    property p_reset; disable iff (1'b0) RST_I |=> !IRQ_O && !PWM_OUTPUT_PIN_OE_O; endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after take");
    a_wait_idle: assert property (p_wait_idle) else $error("stall without request");
    a_oe: assert property (p_oe) else $error("pin enable disagrees with mode");
    a_gated: assert property (p_gated) else $error("pin high while not driven");
    a_period: assert property (p_period) else $error("pwm period wrong");
    a_duty: assert property (p_duty) else $error("pwm high time wrong");
    a_capture: assert property (p_capture) else $error("capture edge raised no interrupt");
    a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule : ccpu_checker
bind ccpu_top ccpu_checker u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CAPTURE_PIN_I(CAPTURE_PIN_I), .PWM_OUTPUT_PIN_O(PWM_OUTPUT_PIN_O),
    .PWM_OUTPUT_PIN_OE_O(PWM_OUTPUT_PIN_OE_O), .IRQ_O(IRQ_O));

// ### bench/ccpu_wave_src.sv
// pulse source standing in for the measured waveform
`timescale 1ns/10ps
module ccpu_wave_src (
    input  wire logic REF_CLK_I,   // system clock
    output logic      PIN_O        // waveform into the capture pin
);
    initial PIN_O = 1'b0;  // idle low between pulses
    // one high pulse of exact width, edges just after a clock edge
    task automatic pulse(input int width);
        PIN_O <= 1'b1;
        repeat (width) @(posedge REF_CLK_I);
        PIN_O <= 1'b0;
    endtask : pulse
endmodule : ccpu_wave_src

// ### bench/tb.sv
// self-checking bench of the capture/compare/pwm unit
`timescale 1ns/10ps
module tb;
    import ccpu_pkg::*;
    logic        clk = 1'b0;      // system clock
    logic        rst = 1'b1;      // sync reset
    logic [3:0]  addr = 4'h0;     // bus address
    logic        rd = 1'b0;       // bus read
    logic        wr = 1'b0;       // bus write
    logic [31:0] wdata = 32'h0;   // bus write data
    logic [31:0] rdata;           // bus read data
    logic        wreq;            // slave stall
    logic        pin;             // capture input
    logic        pwm;             // pwm pin
    logic        oe;              // pwm pin enable
    logic        irq;             // interrupt
    logic [31:0] q;               // last word read
    logic [31:0] seed = 32'h39;   // xorshift state
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int hi, per, t1, p;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ccpu_top dut (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
        .CAPTURE_PIN_I(pin), .PWM_OUTPUT_PIN_O(pwm), .PWM_OUTPUT_PIN_OE_O(oe), .IRQ_O(irq));
    ccpu_wave_src src (.REF_CLK_I(clk), .PIN_O(pin));
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'hFFFF);
    endfunction : rnd
    function automatic int pscale(input int s);
        return (s == 0) ? 1 : (s == 1) ? 4 : 16;
    endfunction : pscale
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            test_done();
        end
    endtask : bus
    // bounded wait for a level on a design output
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            test_done();
        end
    endtask : wait_sig
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, read-only and unmapped places
        bus(1, OFS_CAPTURE, 32'hFFFFFFFF);
        bus(1, 4'h9, 32'hFF);
        for (int i = 0; i < 10; i++) begin
            if (i != 8) begin
                bus(0, i[3:0], 32'h0);
                check(q, (i == 2) ? 32'hFFFF : (i == 3) ? 32'hFF : 32'h0);
            end
        end
        // pulse width by rising then falling capture, every prescale
        bus(1, OFS_MASK, 32'h1);
        for (p = 0; p < 4; p++) begin
            bus(1, OFS_PRESCALE, p);
            bus(1, OFS_CONTROL, MODE_CAP_RISE);
            hi = (24 + rnd() % 30) << p;
            fork
                src.pulse(hi);
            join_none
            wait_sig(irq, 1'b1, 100);
            bus(0, OFS_STATUS, 32'h0);
            bus(0, OFS_CAPTURE, 32'h0);
            t1 = q;
            bus(1, OFS_CONTROL, MODE_CAP_FALL);
            wait_sig(irq, 1'b1, 1000);
            bus(0, OFS_STATUS, 32'h0);
            check(q, 32'h1);
            bus(0, OFS_CAPTURE, 32'h0);
            check((q - t1) & 32'hFFFF, hi >> p);
            repeat (2) @(posedge clk);
            check(irq, 1'b0);
        end
        // masked event stays in status only
        bus(1, OFS_MASK, 32'h0);
        src.pulse(6);
        repeat (10) @(posedge clk);
        check(irq, 1'b0);
        bus(0, OFS_STATUS, 32'h0);
        check(q, 32'h1);
        // special event spacing
        bus(1, OFS_PRESCALE, 32'h0);
        bus(1, OFS_MASK, 32'h2);
        bus(1, OFS_CONTROL, MODE_SPECIAL);
        bus(0, OFS_TIMER, 32'h0);
        bus(1, OFS_COMPARE, (q + 60) & 32'hFFFF);
        wait_sig(irq, 1'b1, 300);
        hi = 50 + rnd() % 50;
        bus(1, OFS_COMPARE, hi);
        bus(0, OFS_STATUS, 32'h0);
        wait_sig(irq, 1'b1, 300);
        t1 = cyc;
        bus(0, OFS_STATUS, 32'h0);
        wait_sig(irq, 1'b1, 300);
        check(cyc - t1, hi + 1);
        // pwm: random settings, last pass full-scale duty
        bus(1, OFS_MASK, 32'h0);
        for (p = 0; p < 4; p++) begin
            per = (p == 3) ? 255 : 8 + rnd() % 32;
            hi = (p == 3) ? 1023 : 1 + rnd() % ((per + 1) * 4 - 1);
            bus(1, OFS_CONTROL, MODE_OFF);
            bus(1, OFS_PERIOD, per);
            bus(1, OFS_DUTY_HI, hi >> 2);
            bus(1, OFS_PRESCALE, p << 4);
            bus(0, OFS_STATUS, 32'h0);
            bus(1, OFS_CONTROL, {hi[1:0], MODE_PWM | 4'(p)});
            wait_sig(pwm, 1'b1, 20000);
            t1 = cyc;
            wait_sig(pwm, 1'b0, 20000);
            check(cyc - t1, hi * pscale(p));
            wait_sig(pwm, 1'b1, 20000);
            check(cyc - t1, (per + 1) * 4 * pscale(p));
            check(oe, 1'b1);
            bus(0, OFS_STATUS, 32'h0);
            check(q, 32'hC);
        end
        bus(1, OFS_CONTROL, MODE_OFF);
        repeat (2) @(posedge clk);
        check({oe, pwm}, 32'h0);
        test_done();
    end
endmodule : tb

// ### rtl/ccpu_pkg.sv
// shared constants, register map and carrier types of the capture/compare/pwm unit
package ccpu_pkg;
    // register word offsets on the avalon slave
    localparam logic [3:0] OFS_CONTROL  = 4'h0;  // unit_control_reg
    localparam logic [3:0] OFS_CAPTURE  = 4'h1;  // captured capture_timebase value
    localparam logic [3:0] OFS_COMPARE  = 4'h2;  // compare value
    localparam logic [3:0] OFS_PERIOD   = 4'h3;  // pwm_period_reg
    localparam logic [3:0] OFS_DUTY_HI  = 4'h4;  // duty_high_byte
    localparam logic [3:0] OFS_PRESCALE = 4'h5;  // prescaler selects
    localparam logic [3:0] OFS_STATUS   = 4'h6;  // sticky events, clear on read
    localparam logic [3:0] OFS_MASK     = 4'h7;  // interrupt mask
    localparam logic [3:0] OFS_TIMER    = 4'h8;  // live capture_timebase count
    // control register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;
    localparam int DUTY_LSB = 4;
    localparam int DUTY_MSB = 5;
    // mode field encodings
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    localparam logic [3:0] MODE_PWM     = 4'hC;  // 4'hC..4'hF all pwm
    // status / mask bits
    localparam int EV_CAPTURE = 0;
    localparam int EV_COMPARE = 1;
    localparam int EV_PERIOD  = 2;
    localparam int EV_WIDTH   = 3;
    // pwm: each timebase tick is this many prescaled clocks
    localparam int PWM_CLKS_PER_TICK = 4;
    // reset values
    localparam logic [7:0]  PERIOD_RESET  = 8'hFF;
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    // software register image
    typedef struct packed {
        logic [7:0]  control;
        logic [15:0] compare;
        logic [7:0]  period;
        logic [7:0]  duty_hi;
        logic [1:0]  cap_pre;   // capture timebase prescale select 1/2/4/8
        logic [1:0]  pwm_pre;   // pwm timebase prescale select 1/4/16/16
        logic [3:0]  mask;
    } ccpu_regs_t;
endpackage : ccpu_pkg

// ### rtl/ccpu_prescaler.sv
// programmable prescaler producing one-cycle tick enables
`timescale 1ns/10ps
module ccpu_prescaler #(
    parameter int WIDTH = 4
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_I,
    input  wire logic             EN_I,       // count only while enabled
    input  wire logic [WIDTH-1:0] DIV_I,      // ratio minus one
    output logic                  TICK_O      // one-cycle enable pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;  // cycles since last tick
    } ccpu_pre_state_t;

    ccpu_pre_state_t st;
    ccpu_pre_state_t next_st;

    // wrap at the ratio; a lowered ratio mid-count wraps at once
    always_comb begin
        next_st = st;
        if (!EN_I) begin
            next_st.cnt = '0;
        end else if (st.cnt >= DIV_I) begin
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + WIDTH'(1);
        end
    end

    assign TICK_O = EN_I && (st.cnt >= DIV_I);

    // state register
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ccpu_prescaler

// ### rtl/ccpu_sync.sv
// two-stage synchroniser with edge pulses for the capture input pin
`timescale 1ns/10ps
module ccpu_sync (
    input  wire logic REF_CLK_I,
    input  wire logic RST_I,
    input  wire logic PIN_I,     // asynchronous pin level
    output logic      LEVEL_O,   // synchronised level
    output logic      RISE_O,    // one-cycle rising edge pulse
    output logic      FALL_O     // one-cycle falling edge pulse
);
    typedef struct packed {
        logic meta;   // first stage, read only by second
        logic sync;   // second stage
        logic last;   // previous synchronised level
    } ccpu_sync_state_t;

    ccpu_sync_state_t st;
    ccpu_sync_state_t next_st;

    // shift chain
    always_comb begin
        next_st      = st;
        next_st.meta = PIN_I;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end

    assign LEVEL_O = st.sync;
    assign RISE_O  = st.sync && !st.last;
    assign FALL_O  = !st.sync && st.last;

    // state register
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ccpu_sync

// ### rtl/ccpu_top.sv
// capture/compare/pwm unit with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module ccpu_top
    import ccpu_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // avalon-mm slave, word addressed
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // pins and interrupt
    input  wire logic        CAPTURE_PIN_I,
    output logic             PWM_OUTPUT_PIN_O,
    output logic             PWM_OUTPUT_PIN_OE_O,
    output logic             IRQ_O
);
    import ccpu_pkg::*;

    typedef struct packed {
        ccpu_regs_t  regs;        // software registers
        logic [15:0] timer;       // capture_timebase
        logic [15:0] capture;     // latched timebase value
        logic [3:0]  status;      // sticky events
        logic [7:0]  pwm_count;   // pwm_timebase
        logic [1:0]  pwm_fine;    // quarter-tick phase, the low duty bits
        logic [9:0]  duty_live;   // duty in use for the current period
        logic        pwm_out;     // output level register
        logic        ack;         // bus answer phase
        logic [31:0] rdata;       // read data register
    } ccpu_state_t;

    ccpu_state_t st;
    ccpu_state_t next_st;

    logic        pin_rise;    // synchronised edges
    logic        pin_fall;
    logic        cap_tick;    // capture timebase enable
    logic        pwm_tick;    // pwm prescaled system-clock enable
    logic [3:0]  mode;
    logic        is_pwm;
    logic [3:0]  cap_div;
    logic [3:0]  pwm_div;
    logic        cap_edge;
    logic [3:0]  events;
    logic        req;

    // byte-enable merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // prescale select to ratio-minus-one
    function automatic logic [3:0] cap_ratio(input logic [1:0] sel);
        return 4'((4'h1 << sel) - 4'h1);
    endfunction : cap_ratio

    assign mode    = st.regs.control[MODE_MSB:MODE_LSB];
    assign is_pwm  = (mode[3:2] == 2'b11);
    assign cap_div = cap_ratio(st.regs.cap_pre);
    // pwm prescale 1, 4 or 16 on top of the fixed four clocks per tick
    assign pwm_div = (st.regs.pwm_pre == 2'h0) ? 4'h0 : ((st.regs.pwm_pre == 2'h1) ? 4'h3 : 4'hF);
    assign req     = (AVS_READ_I || AVS_WRITE_I) && !st.ack;

    // capture pin edges, synchronised first
    ccpu_sync u_sync (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .PIN_I     (CAPTURE_PIN_I),
        .LEVEL_O   (),
        .RISE_O    (pin_rise),
        .FALL_O    (pin_fall)
    );

    // capture timebase prescaler
    ccpu_prescaler #(.WIDTH(4)) u_cap_pre (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .EN_I      (1'b1),
        .DIV_I     (cap_div),
        .TICK_O    (cap_tick)
    );

    // pwm prescaler, runs only in pwm mode so a period starts clean
    ccpu_prescaler #(.WIDTH(4)) u_pwm_pre (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .EN_I      (is_pwm),
        .DIV_I     (pwm_div),
        .TICK_O    (pwm_tick)
    );

    // edge chosen by the live mode field, so a rewrite steers the next edge
    always_comb begin
        cap_edge = 1'b0;
        if (mode == MODE_CAP_RISE) begin
            cap_edge = pin_rise;
        end else if (mode == MODE_CAP_FALL) begin
            cap_edge = pin_fall;
        end
    end

    // next-state logic for the whole unit
    always_comb begin
        next_st = st;
        events  = '0;

        // capture timebase free-runs at the prescaled rate
        if (cap_tick) begin
            next_st.timer = st.timer + 16'h0001;
        end

        // capture latches the count seen at the edge
        if (cap_edge) begin
            next_st.capture     = st.timer;
            events[EV_CAPTURE] = 1'b1;
        end

        // special event: match fires once and restarts the timebase
        if (mode == MODE_SPECIAL && cap_tick && st.timer == st.regs.compare) begin
            events[EV_COMPARE] = 1'b1;
            next_st.timer      = 16'h0000;
        end

        // pwm: fine phase counts 4 prescaled clocks, then the timebase steps
        if (!is_pwm) begin
            next_st.pwm_count = 8'h00;
            next_st.pwm_fine  = 2'h0;
            next_st.pwm_out   = 1'b0;
            next_st.duty_live = {st.regs.duty_hi, st.regs.control[DUTY_MSB:DUTY_LSB]};
        end else if (pwm_tick) begin
            next_st.pwm_fine = st.pwm_fine + 2'h1;
            if (st.pwm_fine == 2'(PWM_CLKS_PER_TICK - 1)) begin
                if (st.pwm_count == st.regs.period) begin
                    // period end: restart, reload duty, raise output
                    next_st.pwm_count   = 8'h00;
                    next_st.duty_live   = {st.regs.duty_hi, st.regs.control[DUTY_MSB:DUTY_LSB]};
                    next_st.pwm_out     = 1'b1;
                    events[EV_PERIOD]   = 1'b1;
                end else begin
                    next_st.pwm_count = st.pwm_count + 8'h01;
                end
            end
            // drop when the count just reached equals the duty value, so the high
            // time is exactly duty slots and duty 0 keeps the pin low all period
            if ({next_st.pwm_count, next_st.pwm_fine} == next_st.duty_live && next_st.pwm_out) begin
                next_st.pwm_out   = 1'b0;
                events[EV_WIDTH]  = 1'b1;
            end
        end

        // bus: one-cycle wait, answer on the following edge
        next_st.ack = req;
        if (req && AVS_WRITE_I) begin
            if (AVS_ADDRESS_I == OFS_CONTROL) begin
                next_st.regs.control = 8'(merge(32'(st.regs.control), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            end else if (AVS_ADDRESS_I == OFS_COMPARE) begin
                next_st.regs.compare = 16'(merge(32'(st.regs.compare), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            end else if (AVS_ADDRESS_I == OFS_PERIOD) begin
                next_st.regs.period = 8'(merge(32'(st.regs.period), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            end else if (AVS_ADDRESS_I == OFS_DUTY_HI) begin
                next_st.regs.duty_hi = 8'(merge(32'(st.regs.duty_hi), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            end else if (AVS_ADDRESS_I == OFS_PRESCALE) begin
                if (AVS_BYTEENABLE_I[0]) begin
                    next_st.regs.cap_pre = AVS_WRITEDATA_I[1:0];
                    next_st.regs.pwm_pre = AVS_WRITEDATA_I[5:4];
                end
            end else if (AVS_ADDRESS_I == OFS_MASK) begin
                if (AVS_BYTEENABLE_I[0]) begin
                    next_st.regs.mask = AVS_WRITEDATA_I[3:0];
                end
            end
        end

        // read data registered; unmapped reads return zero
        next_st.rdata = 32'h0000_0000;
        if (req && AVS_READ_I) begin
            if (AVS_ADDRESS_I == OFS_CONTROL) begin
                next_st.rdata = {24'h000000, st.regs.control};
            end else if (AVS_ADDRESS_I == OFS_CAPTURE) begin
                next_st.rdata = {16'h0000, st.capture};
            end else if (AVS_ADDRESS_I == OFS_COMPARE) begin
                next_st.rdata = {16'h0000, st.regs.compare};
            end else if (AVS_ADDRESS_I == OFS_PERIOD) begin
                next_st.rdata = {24'h000000, st.regs.period};
            end else if (AVS_ADDRESS_I == OFS_DUTY_HI) begin
                next_st.rdata = {24'h000000, st.regs.duty_hi};
            end else if (AVS_ADDRESS_I == OFS_PRESCALE) begin
                next_st.rdata = {26'h0, st.regs.pwm_pre, 2'h0, st.regs.cap_pre};
            end else if (AVS_ADDRESS_I == OFS_STATUS) begin
                next_st.rdata = {28'h0000000, st.status};
            end else if (AVS_ADDRESS_I == OFS_MASK) begin
                next_st.rdata = {28'h0000000, st.regs.mask};
            end else if (AVS_ADDRESS_I == OFS_TIMER) begin
                next_st.rdata = {16'h0000, st.timer};
            end
        end else begin
            next_st.rdata = st.rdata;
        end

        // status read clears, but a new event in the same cycle wins
        if (req && AVS_READ_I && AVS_ADDRESS_I == OFS_STATUS) begin
            next_st.status = events;
        end else begin
            next_st.status = st.status | events;
        end
    end

    assign AVS_WAITREQUEST_O   = (AVS_READ_I || AVS_WRITE_I) && !st.ack;
    assign AVS_READDATA_O      = st.rdata;
    assign PWM_OUTPUT_PIN_O    = st.pwm_out && is_pwm;
    assign PWM_OUTPUT_PIN_OE_O = is_pwm;
    assign IRQ_O               = |(st.status & st.regs.mask);

    // state register
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            st                <= '0;
            st.regs.period    <= PERIOD_RESET;
            st.regs.compare   <= COMPARE_RESET;
        end else begin
            st <= next_st;
        end
    end
endmodule : ccpu_top
